// ---- rtl/txdesc_pkg.sv ----
package txdesc_pkg;

	// ----------------------------------------
	// descriptor word 0 fields and word 1 buffer sizes
	// ----------------------------------------
	localparam int OWN_BIT          = 31;
	localparam int IOC_BIT          = 30;
	localparam int LAST_BIT         = 29;
	localparam int FIRST_BIT        = 28;
	localparam int CRC_SUP_BIT      = 27;
	localparam int PAD_SUP_BIT      = 26;
	localparam int TS_REQ_BIT       = 25;
	localparam int CRC_RECOMP_BIT   = 24;
	localparam int CSUM_HI_BIT      = 23;
	localparam int CSUM_LO_BIT      = 22;
	localparam int RING_WRAP_BIT    = 21;
	localparam int CHAIN_BIT        = 20;
	localparam int BUF2_SIZE_HI     = 28;
	localparam int BUF2_SIZE_LO     = 16;
	localparam int BUF1_SIZE_HI     = 12;
	localparam int BUF1_SIZE_LO     = 0;

	// ----------------------------------------
	// memory layout
	// ----------------------------------------
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0020;
	localparam logic [31:0] WORD1_OFS   = 32'h0000_0004;
	localparam logic [31:0] WORD2_OFS   = 32'h0000_0008;
	localparam logic [31:0] WORD3_OFS   = 32'h0000_000C;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] STATUS_OFS   = 8'h14;
	localparam logic [7:0] MASK_OFS     = 8'h1C;
	localparam logic [7:0] BASE_OFS     = 8'h10;
	localparam logic [7:0] CUR_OFS      = 8'h48;
	localparam logic [7:0] OPTS_OFS     = 8'h4C;
	localparam logic [7:0] POLL_OFS     = 8'h04;
	localparam int         STAT_TX_DONE = 0;
	localparam int         STAT_STALL   = 1;
	localparam int         STAT_BUF     = 2;
	localparam int         NSTAT        = 3;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ----------------------------------------
	// checksum modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		CSUM_NONE   = 2'h0,
		CSUM_IPHDR  = 2'h1,
		CSUM_NOPSH  = 2'h2,
		CSUM_FULL   = 2'h3
	} csum_mode_t;

	typedef struct packed {
		logic       crc_append;
		logic       crc_recompute;
		logic       pad_enable;
		logic       timestamp_request;
		csum_mode_t checksum_offload_select;
	} frame_opts_t;

	typedef struct packed {
		logic        valid;
		logic        first_segment;
		logic        last_segment;
		logic [31:0] addr;
		logic [12:0] len;
	} seg_cmd_t;

	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;

endpackage : txdesc_pkg

// ---- rtl/desc_cache.sv ----
`timescale 1ns/1ps
module desc_cache (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	input  wire logic [1:0]  rd_idx,
	output logic [31:0]      rd_data
);
	logic [31:0] mem [4];

	// ----------------------------------------
	// word storage
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end
endmodule : desc_cache

// ---- rtl/tx_desc_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - word0 bit 31 set means engine owns descriptor; clear means host owns it.
// - engine clears ownership after frame sent or descriptor buffers drained.
// - completion-interrupt with last-segment sets status bit 0 after frame is sent.
// - bit 29 marks final segment buffer, bit 28 marks opening segment buffer.
// - crc suppress on first segment omits appended crc, else crc appended.
// - pad suppress stops padding short frames; padding forces crc append.
// - timestamp request on first segment enables timestamp capture for the frame.
// - crc recompute with crc suppress overwrites last four bytes with new crc.
// - two-bit checksum field on first segment selects one of four offload modes.
// - ring wrap bit makes next descriptor come from list base address.
// - chained bit makes second address the next pointer, ignoring buffer2 size.
// - with both ring wrap and chained set, ring wrap wins.
// - each descriptor occupies eight consecutive 32-bit words.
module tx_desc_ctrl (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite slave
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// descriptor memory port
	output txdesc_pkg::mem_req_t         mem_req,
	input  wire logic                    mem_ack,
	input  wire logic [31:0]             mem_rdata,
	// segment stream to transmit datapath
	output txdesc_pkg::seg_cmd_t         seg_cmd,
	output txdesc_pkg::frame_opts_t      frame_opts,
	input  wire logic                    seg_ready,
	input  wire logic                    seg_done,
	input  wire logic                    frame_sent,
	output logic                         irq
);
	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_RD    = 8'h02,
		S_CHECK = 8'h04,
		S_SEG1  = 8'h08,
		S_SEG2  = 8'h10,
		S_SENT  = 8'h20,
		S_WB    = 8'h40,
		S_NEXT  = 8'h80
	} state_t;

	state_t      state_reg;
	logic [31:0] base_reg;
	logic [31:0] cur_reg;
	logic        run_reg;
	logic        poll_reg;
	logic [1:0]  widx_reg;
	logic [1:0]  ridx;
	logic [31:0] w0_reg;
	logic [31:0] w1_reg;
	logic [31:0] w2_reg;
	logic [31:0] w3_reg;
	logic [31:0] cache_q;
	logic        ioc_pend_reg;
	logic [txdesc_pkg::NSTAT-1:0] status_reg;
	logic [txdesc_pkg::NSTAT-1:0] mask_reg;
	logic [txdesc_pkg::NSTAT-1:0] ev;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic        wr_fire;
	logic [31:0] next_addr;
	logic [12:0] buf1_len;
	logic [12:0] buf2_len;

	assign buf1_len = w1_reg[txdesc_pkg::BUF1_SIZE_HI:txdesc_pkg::BUF1_SIZE_LO];
	assign buf2_len = w1_reg[txdesc_pkg::BUF2_SIZE_HI:txdesc_pkg::BUF2_SIZE_LO];

	// ----------------------------------------
	// descriptor word cache
	// ----------------------------------------
	assign ridx = widx_reg;

	desc_cache u_cache (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (state_reg == S_RD && mem_ack),
		.wr_idx  (widx_reg),
		.wr_data (mem_rdata),
		.rd_idx  (ridx),
		.rd_data (cache_q)
	);

	// ----------------------------------------
	// next descriptor address
	// ----------------------------------------
	always_comb begin
		if (w0_reg[txdesc_pkg::RING_WRAP_BIT]) begin
			next_addr = base_reg;
		end else if (w0_reg[txdesc_pkg::CHAIN_BIT]) begin
			next_addr = w3_reg;
		end else begin
			next_addr = cur_reg + txdesc_pkg::DESC_STRIDE;
		end
	end

	// ----------------------------------------
	// descriptor engine
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= S_IDLE;
			cur_reg      <= 32'h0000_0000;
			widx_reg     <= 2'h0;
			w0_reg       <= 32'h0000_0000;
			w1_reg       <= 32'h0000_0000;
			w2_reg       <= 32'h0000_0000;
			w3_reg       <= 32'h0000_0000;
			ioc_pend_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (run_reg && poll_reg) begin
						widx_reg  <= 2'h0;
						state_reg <= S_RD;
					end
				end
				S_RD: begin
					if (mem_ack) begin
						unique case (widx_reg)
							2'h0: w0_reg <= mem_rdata;
							2'h1: w1_reg <= mem_rdata;
							2'h2: w2_reg <= mem_rdata;
							2'h3: w3_reg <= mem_rdata;
						endcase
						if (widx_reg == 2'h3) begin
							state_reg <= S_CHECK;
						end
						widx_reg <= widx_reg + 2'h1;
					end
				end
				S_CHECK: begin
					if (!w0_reg[txdesc_pkg::OWN_BIT]) begin
						state_reg <= S_IDLE;
					end else begin
						if (w0_reg[txdesc_pkg::LAST_BIT] && w0_reg[txdesc_pkg::IOC_BIT]) begin
							ioc_pend_reg <= 1'b1;
						end
						state_reg <= (buf1_len != 13'h0000) ? S_SEG1 : S_SEG2;
					end
				end
				S_SEG1: begin
					if (seg_done) begin
						state_reg <= (!w0_reg[txdesc_pkg::CHAIN_BIT] && buf2_len != 13'h0000) ? S_SEG2 : S_SENT;
					end
				end
				S_SEG2: begin
					if (seg_done || w0_reg[txdesc_pkg::CHAIN_BIT] || buf2_len == 13'h0000) begin
						state_reg <= S_SENT;
					end
				end
				S_SENT: begin
					if (!w0_reg[txdesc_pkg::LAST_BIT] || frame_sent) begin
						state_reg <= S_WB;
					end
				end
				S_WB: begin
					if (mem_ack) begin
						ioc_pend_reg <= 1'b0;
						state_reg    <= S_NEXT;
					end
				end
				S_NEXT: begin
					cur_reg   <= next_addr;
					widx_reg  <= 2'h0;
					state_reg <= S_RD;
				end
				default: state_reg <= S_IDLE;
			endcase
			if (!run_reg) begin
				cur_reg <= base_reg;
			end
		end
	end

	// ----------------------------------------
	// memory and segment outputs
	// ----------------------------------------
	always_comb begin
		mem_req = '0;
		if (state_reg == S_RD) begin
			mem_req.req  = 1'b1;
			mem_req.addr = cur_reg + {28'h0000000, widx_reg, 2'h0};
		end else if (state_reg == S_WB) begin
			mem_req.req   = 1'b1;
			mem_req.write = 1'b1;
			mem_req.addr  = cur_reg;
			mem_req.wdata = w0_reg & ~(32'h0000_0001 << txdesc_pkg::OWN_BIT);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_cmd <= '0;
		end else if (state_reg == S_SEG1 || (state_reg == S_SEG2 && !w0_reg[txdesc_pkg::CHAIN_BIT])) begin
			seg_cmd.valid         <= !seg_done;
			seg_cmd.first_segment <= w0_reg[txdesc_pkg::FIRST_BIT];
			seg_cmd.last_segment  <= w0_reg[txdesc_pkg::LAST_BIT];
			seg_cmd.addr          <= (state_reg == S_SEG1) ? w2_reg : w3_reg;
			seg_cmd.len           <= (state_reg == S_SEG1) ? buf1_len : buf2_len;
		end else begin
			seg_cmd.valid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_opts <= '0;
		end else if (state_reg == S_CHECK && w0_reg[txdesc_pkg::OWN_BIT] && w0_reg[txdesc_pkg::FIRST_BIT]) begin
			frame_opts.pad_enable        <= !w0_reg[txdesc_pkg::PAD_SUP_BIT];
			frame_opts.crc_append        <= !w0_reg[txdesc_pkg::CRC_SUP_BIT]
				|| !w0_reg[txdesc_pkg::PAD_SUP_BIT];
			frame_opts.crc_recompute     <= w0_reg[txdesc_pkg::CRC_RECOMP_BIT]
				&& w0_reg[txdesc_pkg::CRC_SUP_BIT];
			frame_opts.timestamp_request <= w0_reg[txdesc_pkg::TS_REQ_BIT];
			frame_opts.checksum_offload_select <= txdesc_pkg::csum_mode_t'(
				w0_reg[txdesc_pkg::CSUM_HI_BIT:txdesc_pkg::CSUM_LO_BIT]);
		end
	end

	// ----------------------------------------
	// events and interrupt
	// ----------------------------------------
	assign ev[txdesc_pkg::STAT_TX_DONE] = state_reg == S_WB && mem_ack && ioc_pend_reg;
	assign ev[txdesc_pkg::STAT_STALL]   = state_reg == S_CHECK && !w0_reg[txdesc_pkg::OWN_BIT];
	assign ev[txdesc_pkg::STAT_BUF]     = state_reg == S_WB && mem_ack;

	generate
		for (genvar i = 0; i < txdesc_pkg::NSTAT; i++) begin : g_stat
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					status_reg[i] <= 1'b0;
				end else if (ev[i]) begin
					status_reg[i] <= 1'b1;
				end else if (wr_fire && awaddr_reg == txdesc_pkg::STATUS_OFS && wdata_reg[i]) begin
					status_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign irq = |(status_reg & mask_reg);

	// ----------------------------------------
	// axi4-lite write
	// ----------------------------------------
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= txdesc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held    <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held    <= 1'b1;
				wdata_reg <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (awaddr_reg)
					txdesc_pkg::CTRL_OFS, txdesc_pkg::POLL_OFS, txdesc_pkg::BASE_OFS,
					txdesc_pkg::STATUS_OFS, txdesc_pkg::MASK_OFS: s_axi_bresp <= txdesc_pkg::RESP_OKAY;
					default: s_axi_bresp <= txdesc_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_reg  <= 1'b0;
			base_reg <= 32'h0000_0000;
			mask_reg <= '0;
		end else if (wr_fire && s_axi_wstrb == 4'hF) begin
			if (awaddr_reg == txdesc_pkg::CTRL_OFS) begin
				run_reg <= wdata_reg[0];
			end
			if (awaddr_reg == txdesc_pkg::BASE_OFS) begin
				base_reg <= {wdata_reg[31:2], 2'h0};
			end
			if (awaddr_reg == txdesc_pkg::MASK_OFS) begin
				mask_reg <= wdata_reg[txdesc_pkg::NSTAT-1:0];
			end
		end
	end

	// poll demand restarts a stalled engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			poll_reg <= 1'b0;
		end else if (wr_fire && awaddr_reg == txdesc_pkg::POLL_OFS) begin
			poll_reg <= 1'b1;
		end else if (state_reg == S_IDLE && run_reg) begin
			poll_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// axi4-lite read
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= txdesc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= txdesc_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				txdesc_pkg::CTRL_OFS:   s_axi_rdata <= {31'h0, run_reg};
				txdesc_pkg::POLL_OFS:   s_axi_rdata <= 32'h0000_0000;
				txdesc_pkg::BASE_OFS:   s_axi_rdata <= base_reg;
				txdesc_pkg::STATUS_OFS: s_axi_rdata <= {29'h0, status_reg};
				txdesc_pkg::MASK_OFS:   s_axi_rdata <= {29'h0, mask_reg};
				txdesc_pkg::CUR_OFS:    s_axi_rdata <= cur_reg;
				txdesc_pkg::OPTS_OFS:   s_axi_rdata <= {24'h0, state_reg[7:6], frame_opts};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= txdesc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	logic unused_q;
	assign unused_q = ^cache_q;
endmodule : tx_desc_ctrl

// ---- testbench/tx_desc_ctrl_assertions.sv ----
`timescale 1ns/1ps
module tx_desc_ctrl_assertions (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire txdesc_pkg::mem_req_t    mem_req,
	input wire logic                    mem_ack,
	input wire logic [31:0]             mem_rdata,
	input wire txdesc_pkg::seg_cmd_t    seg_cmd,
	input wire txdesc_pkg::frame_opts_t frame_opts
);
	logic [31:0] cap [4];
	logic [31:0] last_rd;
	logic [31:0] nxt;
	logic        nxt_ok;
	logic        rd_ack;
	assign rd_ack = mem_ack && mem_req.req && !mem_req.write;
	// ------
	// fetched words and expected next descriptor
	// ------
	always_ff @(posedge aclk) begin
		if (rd_ack) begin
			cap[mem_req.addr[3:2]] <= mem_rdata;
			last_rd                <= mem_req.addr;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nxt_ok <= 1'b0;
		end else if (mem_ack && mem_req.write) begin
			nxt_ok <= !cap[0][21];
			nxt    <= cap[0][20] ? cap[3] : mem_req.addr + 32'h0000_0020;
		end else if (rd_ack && mem_req.addr[4:0] == 5'h00 && !mem_rdata[31]) begin
			nxt_ok <= 1'b1;
			nxt    <= mem_req.addr;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------
	// checks
	// ------
	AST_HOST_OWNED_IDLE: assert property (rd_ack && mem_req.addr[4:0] == 5'h00 && !mem_rdata[31] |=>
		!(seg_cmd.valid || (mem_req.req && mem_req.write))[*8]) else $error("host owned descriptor used");
	AST_FETCH_SEQ: assert property (mem_req.req && !mem_req.write && mem_req.addr[3:0] != 4'h0 |->
		mem_req.addr == last_rd + 32'h0000_0004) else $error("descriptor word fetch out of sequence");
	AST_WB_OWN_CLEAR: assert property (mem_req.req && mem_req.write |-> !mem_req.wdata[31] &&
		mem_req.wdata[30:20] == cap[0][30:20] && mem_req.addr == last_rd - 32'h0000_000C)
		else $error("write-back word wrong");
	AST_OPTS_DECODE: assert property ($rose(seg_cmd.valid) && cap[0][28] |->
		frame_opts.timestamp_request == cap[0][25] && frame_opts.checksum_offload_select == cap[0][23:22]
		&& frame_opts.pad_enable == !cap[0][26]) else $error("frame options decode wrong");
	AST_CRC_DECODE: assert property ($rose(seg_cmd.valid) && cap[0][28] |->
		frame_opts.crc_append == (!cap[0][27] || !cap[0][26])
		&& frame_opts.crc_recompute == (cap[0][24] && cap[0][27])) else $error("crc options wrong");
	AST_PAD_FORCES_CRC: assert property (frame_opts.pad_enable |-> frame_opts.crc_append)
		else $error("padding without crc");
	AST_OPTS_HOLD: assert property (seg_cmd.valid && $past(seg_cmd.valid) |-> $stable(frame_opts))
		else $error("options changed mid segment");
	AST_SEG_BUF1: assert property ($rose(seg_cmd.valid) && seg_cmd.addr == cap[2] |->
		seg_cmd.first_segment == cap[0][28] && seg_cmd.len == cap[1][12:0]) else $error("buffer1 segment wrong");
	AST_SEG_LAST: assert property ($rose(seg_cmd.valid) && seg_cmd.addr == cap[2] &&
		(cap[0][20] || cap[1][28:16] == 13'h0000) |-> seg_cmd.last_segment == cap[0][29])
		else $error("last segment flag wrong");
	AST_CHAIN_NO_BUF2: assert property ($rose(seg_cmd.valid) && cap[0][20] |-> seg_cmd.addr == cap[2])
		else $error("second buffer used on chained descriptor");
	AST_NEXT_ADDR: assert property (mem_req.req && !mem_req.write && mem_req.addr[4:0] == 5'h00 && nxt_ok
		|-> mem_req.addr == nxt) else $error("next descriptor address wrong");
endmodule : tx_desc_ctrl_assertions

bind tx_desc_ctrl tx_desc_ctrl_assertions chk_u (.aclk, .aresetn, .mem_req, .mem_ack, .mem_rdata, .seg_cmd,
	.frame_opts);

// ---- testbench/desc_host_model.sv ----
`timescale 1ns/1ps
module desc_host_model (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire txdesc_pkg::mem_req_t    mem_req,
	output logic                         mem_ack,
	output logic [31:0]                  mem_rdata,
	input  wire txdesc_pkg::seg_cmd_t    seg_cmd,
	input  wire txdesc_pkg::frame_opts_t frame_opts,
	output logic                         seg_done,
	output logic                         frame_sent
);
	logic [31:0] mem [0:1023];
	logic [50:0] seg_q [$];
	logic [1:0]  wait_cnt;
	logic [1:0]  seg_cnt;
	logic        slow, taken, last_q;
	initial {mem_ack, seg_done, frame_sent, taken, mem_rdata} = '0;
	// ------
	// shared memory, prompt and slow answers in turn
	// ------
	always @(posedge aclk) begin
		if (!aresetn) begin
			mem_ack  <= 1'b0;
			wait_cnt <= 2'h0;
			slow     <= 1'b0;
		end else if (mem_req.req && !mem_ack && wait_cnt == {slow, 1'b0}) begin
			mem_ack  <= 1'b1;
			wait_cnt <= 2'h0;
			slow     <= !slow;
			if (mem_req.write)
				mem[mem_req.addr[11:2]] <= mem_req.wdata;
			else
				mem_rdata <= mem[mem_req.addr[11:2]];
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt  <= wait_cnt + {1'b0, mem_req.req && !mem_ack};
		end
	end
	// ------
	// transmit datapath stand-in
	// ------
	always @(posedge aclk) begin
		frame_sent <= aresetn && seg_done && last_q;
		seg_done   <= aresetn && taken && seg_cnt == 2'h1;
		if (!aresetn || !seg_cmd.valid) begin
			taken <= 1'b0;
		end else if (!taken) begin
			seg_q.push_back({frame_opts, seg_cmd.addr, seg_cmd.len});
			last_q <= seg_cmd.last_segment;
			taken  <= 1'b1;
		end
		seg_cnt <= !taken ? 2'h0 : seg_cnt + {1'b0, seg_cnt != 2'h3};
	end
endmodule : desc_host_model

// ---- testbench/tx_desc_ctrl_tb.sv ----
`timescale 1ns/1ps
module tx_desc_ctrl_tb;
	logic                    aclk, aresetn, irq, mem_ack, seg_ready, seg_done, frame_sent;
	logic [7:0]              s_axi_awaddr, s_axi_araddr;
	logic [31:0]             s_axi_wdata, s_axi_rdata, mem_rdata;
	logic [3:0]              s_axi_wstrb;
	logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]              s_axi_bresp, s_axi_rresp;
	txdesc_pkg::mem_req_t    mem_req;
	txdesc_pkg::seg_cmd_t    seg_cmd;
	txdesc_pkg::frame_opts_t frame_opts;
	int                      n_mismatch, comparisons, cycles;
	// descriptors at 0x100: chained entries skip ahead, last one wraps and chains
	localparam logic [31:0] da [5] = '{32'h100, 32'h140, 32'h160, 32'h180, 32'h1A0};
	localparam logic [31:0] w0 [5] = '{32'h3D10_0000, 32'h5A40_0000, 32'h2FC0_0000, 32'h3580_0000, 32'h7CF0_0000};
	localparam logic [31:0] w1 [5] = '{32'h1FFF_0040, 32'h41, 32'h42, 32'h0020_0043, 32'h1FFF_0044};
	localparam logic [31:0] w3 [5] = '{32'h140, 32'h0, 32'h0, 32'h2000, 32'h300};
	localparam logic [50:0] es [6] = '{{6'h10, 32'h1000, 13'h40}, {6'h2D, 32'h1100, 13'h41},
		{6'h2D, 32'h1200, 13'h42}, {6'h22, 32'h1300, 13'h43}, {6'h22, 32'h2000, 13'h20}, {6'h03, 32'h1400, 13'h44}};

	tx_desc_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_ack, .mem_rdata,
		.seg_cmd, .frame_opts, .seg_ready, .seg_done, .frame_sent, .irq);
	desc_host_model host_u (.aclk, .aresetn, .mem_req, .mem_ack, .mem_rdata, .seg_cmd, .frame_opts, .seg_done,
		.frame_sent);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// ------
	// bus and check tasks
	// ------
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_araddr  <= a;
		s_axi_wdata   <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
		{s_axi_bready, s_axi_rready} <= 2'h0;
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
	endtask : axi
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b1, a, d, q, r);
	endtask : wr
	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'b0, a, 32'h0, q, r);
		chk(n, e, q);
	endtask : rd_chk
	task automatic wait_stall;
		logic [31:0] q;
		logic [1:0]  r;
		q = 32'h0;
		for (int i = 0; i < 100 && !q[1]; i++) axi(1'b0, txdesc_pkg::STATUS_OFS, 32'h0, q, r);
		chk("stall flag", 1'b1, q[1]);
	endtask : wait_stall
	task automatic put(input int i, input logic own);
		host_u.mem[da[i][11:2]] = {own, w0[i][30:0]};
		host_u.mem[da[i][11:2] + 10'h1] = w1[i];
		host_u.mem[da[i][11:2] + 10'h2] = 32'h0000_1000 + 32'(i) * 32'h0000_0100;
		host_u.mem[da[i][11:2] + 10'h3] = w3[i];
	endtask : put
	task automatic chk_segs(input int n);
		chk("segment count", n, host_u.seg_q.size());
		for (int i = 0; i < n; i++) chk("segment", es[i], host_u.seg_q[i]);
	endtask : chk_segs
	task automatic settle_irq(input logic e);
		repeat (2) @(posedge aclk);
		#1 chk("irq", e, irq);
	endtask : settle_irq
	// ------
	// scenarios
	// ------
	task automatic test_regs;
		logic [31:0] q;
		logic [1:0]  r;
		rd_chk("status", txdesc_pkg::STATUS_OFS, 32'h0);
		rd_chk("mask", txdesc_pkg::MASK_OFS, 32'h0);
		axi(1'b0, 8'h08, 32'h0, q, r);
		chk("rresp", txdesc_pkg::RESP_SLVERR, r);
		chk("rdata", 32'h0, q);
		axi(1'b1, 8'h08, 32'h5, q, r);
		chk("bresp", txdesc_pkg::RESP_SLVERR, r);
		wr(txdesc_pkg::BASE_OFS, 32'h0000_0100);
		rd_chk("base", txdesc_pkg::BASE_OFS, 32'h0000_0100);
		$display("test regs done");
	endtask : test_regs
	task automatic test_fetch;
		for (int i = 0; i < 5; i++) put(i, i < 3);
		wr(txdesc_pkg::CTRL_OFS, 32'h0000_0001);
		wr(txdesc_pkg::POLL_OFS, 32'h0000_0001);
		wait_stall();
		rd_chk("cur", txdesc_pkg::CUR_OFS, 32'h0000_0180);
		rd_chk("status", txdesc_pkg::STATUS_OFS, 32'h0000_0006);
		for (int i = 0; i < 3; i++) chk("word0", {1'b0, w0[i][30:0]}, host_u.mem[da[i][11:2]]);
		chk_segs(3);
		$display("test fetch done");
	endtask : test_fetch
	task automatic test_wrap;
		wr(txdesc_pkg::STATUS_OFS, 32'h0000_0007);
		rd_chk("status", txdesc_pkg::STATUS_OFS, 32'h0);
		host_u.mem[da[4][11:2]][31] = 1'b1;
		host_u.mem[da[3][11:2]][31] = 1'b1;
		wr(txdesc_pkg::POLL_OFS, 32'h0000_0001);
		wait_stall();
		rd_chk("cur", txdesc_pkg::CUR_OFS, 32'h0000_0100);
		rd_chk("opts", txdesc_pkg::OPTS_OFS, 32'h0000_0003);
		rd_chk("status", txdesc_pkg::STATUS_OFS, 32'h0000_0007);
		for (int i = 3; i < 5; i++) chk("word0", {1'b0, w0[i][30:0]}, host_u.mem[da[i][11:2]]);
		chk_segs(6);
		$display("test wrap done");
	endtask : test_wrap
	task automatic test_irq;
		settle_irq(1'b0);
		wr(txdesc_pkg::MASK_OFS, 32'h0000_0001);
		settle_irq(1'b1);
		wr(txdesc_pkg::STATUS_OFS, 32'h0000_0001);
		settle_irq(1'b0);
		rd_chk("status", txdesc_pkg::STATUS_OFS, 32'h0000_0006);
		$display("test irq done");
	endtask : test_irq
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		seg_ready = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		test_regs();
		test_fetch();
		test_wrap();
		test_irq();
		complete_run();
	end
endmodule : tx_desc_ctrl_tb
